/* rtl/cfgchk_cfg.svh */
// Constants for the configuration command option checker
`ifndef CFGCHK_CFG_SVH
`define CFGCHK_CFG_SVH

// Option codes
`define CFGCHK_OPT_PICC     8'h00
`define CFGCHK_OPT_SM       8'h04
`define CFGCHK_OPT_CAP      8'h05
`define CFGCHK_OPT_APPREN   8'h06
`define CFGCHK_OPT_ATS      8'h02
`define CFGCHK_OPT_TXCFG    8'h03
`define CFGCHK_OPT_FILEREN  8'h08
`define CFGCHK_OPT_AMOUNT   8'h09
`define CFGCHK_OPT_FAILCTR  8'h0a
`define CFGCHK_OPT_MODSEL   8'h0b

// Payload lengths
`define CFGCHK_LEN_AMOUNT   5'd14
`define CFGCHK_LEN_FAILCTR  5'd5
`define CFGCHK_LEN_MODSEL   5'd1
`define CFGCHK_LEN_ONE      5'd1
`define CFGCHK_LEN_TWO      5'd2
`define CFGCHK_LEN_CAP      5'd10
`define CFGCHK_LEN_REN_BASE 5'd3
`define CFGCHK_LEN_ID       5'd2
`define CFGCHK_LEN_PAIR     5'd2
`define CFGCHK_LEN_APP_A    5'd17
`define CFGCHK_LEN_APP_B    5'd19
`define CFGCHK_MAX_LEN      5'd19

// Status bytes
`define CFGCHK_SW1          8'h91
`define CFGCHK_OK           8'h00
`define CFGCHK_ABORT        8'hca
`define CFGCHK_INTEG        8'h1e
`define CFGCHK_LENGTH       8'h7e
`define CFGCHK_PARAM        8'h9e
`define CFGCHK_REFUSED      8'h9d
`define CFGCHK_MISSING      8'hf0
`define CFGCHK_AUTH         8'hae

// Reserved identifiers
`define CFGCHK_ID_RES0      16'h0000
`define CFGCHK_ID_RES1      16'h3f00
`define CFGCHK_ID_RES2      16'h3fff
`define CFGCHK_ID_RES3      16'hffff

// Reset values
`define CFGCHK_THR_DEF      16'd1000
`define CFGCHK_STEP_DEF     16'd10

`endif

/* rtl/cfgchk_pkg.sv */
// Types for the configuration command option checker
package cfgchk_pkg;

  typedef enum logic [1:0] {
    CFGCHK_IDLE = 2'b00,
    CFGCHK_RECV = 2'b01,
    CFGCHK_EVAL = 2'b10,
    CFGCHK_RESP = 2'b11
  } cfgchk_state_t;

  typedef struct packed {
    logic        amount_valid;
    logic [31:0] amount_floor;
    logic [31:0] amount_ceiling;
    logic [31:0] amount_current;
    logic [7:0]  amount_file;
    logic        read_amount_free;
    logic        capped_credit_en;
    logic        amount_done;
    logic        auth_fail_counter_enable;
    logic [15:0] auth_fail_threshold;
    logic [15:0] auth_fail_step;
    logic        strong_modulation;
  } cfgchk_conf_t;

  typedef struct packed {
    cfgchk_state_t st;
    logic [7:0]    opt;
    logic [4:0]    cnt;
    logic [151:0]  buf_q;
    logic          ovf;
    logic          rsp_valid;
    logic [15:0]   status_word;
    logic          apply;
    cfgchk_conf_t  conf;
  } cfgchk_regs_t;

endpackage

/* rtl/cfgchk_checker.sv */
// Configuration command option checker and applied settings
`timescale 1ns/1ps
`include "cfgchk_cfg.svh"

module cfgchk_checker
  import cfgchk_pkg::*;
#(
  parameter int MAX_LEN = 19
) (
  // Clock and reset
  input  wire logic          core_clk,
  input  wire logic          rst,
  // Command stream
  input  wire logic          cmd_start,
  input  wire logic [7:0]    cmd_option,
  input  wire logic          data_valid,
  input  wire logic [7:0]    data_byte,
  input  wire logic          cmd_end,
  // Session context
  input  wire logic          chain_busy,
  input  wire logic          integrity_bad,
  input  wire logic          root_key_auth,
  input  wire logic          target_exists,
  input  wire logic          target_is_amount,
  // Response
  output logic               rsp_valid,
  output logic [15:0]        status_word,
  output logic               cfg_apply,
  output cfgchk_conf_t       conf
);

  cfgchk_regs_t r_q;
  cfgchk_regs_t r_d;

  // Payload byte n sits at buf bits [8n+7:8n]
  function automatic logic [7:0] pb(input logic [151:0] b, input int n);
    pb = b[n*8 +: 8];
  endfunction

  function automatic logic id_reserved(input logic [15:0] id);
    id_reserved = (id == `CFGCHK_ID_RES0) || (id == `CFGCHK_ID_RES1) ||
                  (id == `CFGCHK_ID_RES2) || (id == `CFGCHK_ID_RES3);
  endfunction

  // Decoded payload fields
  logic [7:0]  renaming_option_byte;
  logic [7:0]  lead_byte;
  logic [15:0] first_file_new_iso_ident;
  logic [7:0]  second_file_current_number;
  logic [7:0]  second_file_new_number;
  logic [15:0] second_file_new_iso_ident;
  logic [4:0]  ren_len;
  logic [4:0]  id2_pos;
  logic [31:0] amount_floor;
  logic [31:0] amount_ceiling;
  logic [31:0] amount_current;
  logic [7:0]  amount_file_flags;
  logic        len_bad;
  logic        param_bad;
  logic        known;
  logic [7:0]  err;

  ////////////////////////////////////////////////////////////////////////////
  // Field decode and checks
  always_comb begin
    renaming_option_byte       = pb(r_q.buf_q, 0);
    lead_byte                  = pb(r_q.buf_q, 0);
    // Optional identifier follows the two file-number bytes
    first_file_new_iso_ident   = {pb(r_q.buf_q, 4), pb(r_q.buf_q, 3)};
    id2_pos                    = renaming_option_byte[0] ? 5'd5 : 5'd3;
    second_file_current_number = pb(r_q.buf_q, int'(id2_pos));
    second_file_new_number     = pb(r_q.buf_q, int'(id2_pos) + 1);
    second_file_new_iso_ident  = {pb(r_q.buf_q, int'(id2_pos) + 3),
                                  pb(r_q.buf_q, int'(id2_pos) + 2)};
    ren_len = `CFGCHK_LEN_REN_BASE
            + (renaming_option_byte[0] ? `CFGCHK_LEN_ID : 5'd0)
            + (renaming_option_byte[1] ? `CFGCHK_LEN_PAIR : 5'd0)
            + ((renaming_option_byte[1] && renaming_option_byte[0]) ? `CFGCHK_LEN_ID : 5'd0);
    amount_floor      = {pb(r_q.buf_q, 4), pb(r_q.buf_q, 3), pb(r_q.buf_q, 2), pb(r_q.buf_q, 1)};
    amount_ceiling    = {pb(r_q.buf_q, 8), pb(r_q.buf_q, 7), pb(r_q.buf_q, 6), pb(r_q.buf_q, 5)};
    amount_current    = {pb(r_q.buf_q, 12), pb(r_q.buf_q, 11), pb(r_q.buf_q, 10), pb(r_q.buf_q, 9)};
    amount_file_flags = pb(r_q.buf_q, 13);
    known     = 1'b1;
    len_bad   = r_q.ovf;
    param_bad = 1'b0;
    unique case (r_q.opt)
      `CFGCHK_OPT_PICC, `CFGCHK_OPT_MODSEL: len_bad |= (r_q.cnt != `CFGCHK_LEN_ONE);
      `CFGCHK_OPT_TXCFG, `CFGCHK_OPT_SM:    len_bad |= (r_q.cnt != `CFGCHK_LEN_TWO);
      `CFGCHK_OPT_CAP:    len_bad |= (r_q.cnt != `CFGCHK_LEN_CAP);
      `CFGCHK_OPT_AMOUNT: len_bad |= (r_q.cnt != `CFGCHK_LEN_AMOUNT);
      `CFGCHK_OPT_FAILCTR: len_bad |= (r_q.cnt != `CFGCHK_LEN_FAILCTR);
      `CFGCHK_OPT_APPREN: len_bad |= (r_q.cnt != `CFGCHK_LEN_APP_A) && (r_q.cnt != `CFGCHK_LEN_APP_B);
      `CFGCHK_OPT_FILEREN: len_bad |= (r_q.cnt != ren_len);
      `CFGCHK_OPT_ATS: len_bad |= (r_q.cnt < 5'd5) || (r_q.cnt > 5'd20);
      default: known = 1'b0;
    endcase
    // Value checks
    if (r_q.opt == `CFGCHK_OPT_FILEREN) begin
      param_bad = (renaming_option_byte[0] && id_reserved(first_file_new_iso_ident))
               || (renaming_option_byte[1] && renaming_option_byte[0]
                   && id_reserved(second_file_new_iso_ident));
    end
    if (r_q.opt == `CFGCHK_OPT_AMOUNT) begin
      param_bad = ($signed(amount_floor) > $signed(amount_ceiling))
               || ($signed(amount_current) < $signed(amount_floor))
               || ($signed(amount_current) > $signed(amount_ceiling));
    end
    if (r_q.opt == `CFGCHK_OPT_FAILCTR) begin
      param_bad = lead_byte[0] && ({pb(r_q.buf_q, 2), pb(r_q.buf_q, 1)} == 16'h0000);
    end
    // Fixed priority of error reporting
    if (chain_busy)                       err = `CFGCHK_ABORT;
    else if (integrity_bad)               err = `CFGCHK_INTEG;
    else if (known && len_bad)            err = `CFGCHK_LENGTH;
    else if (!root_key_auth)              err = `CFGCHK_AUTH;
    else if (!known || param_bad)         err = `CFGCHK_PARAM;
    else if ((r_q.opt == `CFGCHK_OPT_AMOUNT) && !target_exists) err = `CFGCHK_MISSING;
    else if ((r_q.opt == `CFGCHK_OPT_AMOUNT) && (r_q.conf.amount_done || !target_is_amount))
                                          err = `CFGCHK_REFUSED;
    else                                  err = `CFGCHK_OK;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    r_d           = r_q;
    r_d.rsp_valid = 1'b0;
    r_d.apply     = 1'b0;
    unique case (r_q.st)
      CFGCHK_IDLE: begin
        if (cmd_start) begin
          r_d.st    = CFGCHK_RECV;
          r_d.opt   = cmd_option;
          r_d.cnt   = 5'd0;
          r_d.ovf   = 1'b0;
          r_d.buf_q = '0;
        end
      end
      CFGCHK_RECV: begin
        // Store bytes; excess bytes only flag an overflow
        if (data_valid) begin
          if (r_q.cnt < 5'(MAX_LEN)) begin
            r_d.buf_q[r_q.cnt*8 +: 8] = data_byte;
            r_d.cnt = r_q.cnt + 5'd1;
          end else begin
            r_d.ovf = 1'b1;
          end
        end
        if (cmd_end) begin
          r_d.st = CFGCHK_EVAL;
        end
      end
      CFGCHK_EVAL: begin
        r_d.st          = CFGCHK_RESP;
        r_d.rsp_valid   = 1'b1;
        r_d.status_word = {`CFGCHK_SW1, err};
        if (err == `CFGCHK_OK) begin
          r_d.apply = 1'b1;
          if (r_q.opt == `CFGCHK_OPT_AMOUNT) begin
            r_d.conf.amount_valid     = 1'b1;
            r_d.conf.amount_done      = 1'b1;
            r_d.conf.amount_file      = pb(r_q.buf_q, 0);
            r_d.conf.amount_floor     = amount_floor;
            r_d.conf.amount_ceiling   = amount_ceiling;
            r_d.conf.amount_current   = amount_current;
            r_d.conf.read_amount_free = amount_file_flags[1];
            r_d.conf.capped_credit_en = amount_file_flags[0];
          end
          if (r_q.opt == `CFGCHK_OPT_FAILCTR) begin
            r_d.conf.auth_fail_counter_enable = lead_byte[0];
            if (lead_byte[0]) begin
              r_d.conf.auth_fail_threshold = {pb(r_q.buf_q, 2), pb(r_q.buf_q, 1)};
              r_d.conf.auth_fail_step      = {pb(r_q.buf_q, 4), pb(r_q.buf_q, 3)};
            end
          end
          if (r_q.opt == `CFGCHK_OPT_MODSEL) begin
            r_d.conf.strong_modulation = lead_byte[0];
          end
        end
      end
      CFGCHK_RESP: begin
        r_d.st = CFGCHK_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge core_clk) begin
    if (rst) begin
      r_q                               <= '0;
      r_q.st                            <= CFGCHK_IDLE;
      r_q.conf.auth_fail_counter_enable <= 1'b1;
      r_q.conf.auth_fail_threshold      <= `CFGCHK_THR_DEF;
      r_q.conf.auth_fail_step           <= `CFGCHK_STEP_DEF;
      r_q.conf.strong_modulation        <= 1'b1;
    end else begin
      r_q <= r_d;
    end
  end

  // Outputs straight from flops
  assign rsp_valid   = r_q.rsp_valid;
  assign status_word = r_q.status_word;
  assign cfg_apply   = r_q.apply;
  assign conf        = r_q.conf;

endmodule

/* sim/cfgchk_reader.sv */
// Reader model that sends configuration command frames
`timescale 1ns/1ps
module cfgchk_reader (
  // Clock
  input  wire logic       core_clk,
  // Command stream
  output logic            cmd_start,
  output logic [7:0]      cmd_option,
  output logic            data_valid,
  output logic [7:0]      data_byte,
  output logic            cmd_end
);
  // Idle levels
  initial begin
    cmd_start  = 1'b0;
    cmd_option = 8'h00;
    data_valid = 1'b0;
    data_byte  = 8'h00;
    cmd_end    = 1'b0;
  end

  // One frame: start with option, bytes lowest first, end on last byte
  task automatic send(input logic [7:0] opt, input logic [4:0] n, input logic [151:0] pl);
    int i;
    @(posedge core_clk);
    #1;
    cmd_start  = 1'b1;
    cmd_option = opt;
    @(posedge core_clk);
    #1;
    cmd_start  = 1'b0;
    cmd_option = ~opt; // Released field no longer shows the code
    for (i = 0; i < int'(n); i++) begin
      data_valid = 1'b1;
      data_byte  = pl[8*i +: 8];
      cmd_end    = (i == int'(n) - 1);
      @(posedge core_clk);
      #1;
    end
    data_valid = 1'b0;
    cmd_end    = 1'b0;
    data_byte  = ~data_byte; // Released byte lane toggles
  endtask
endmodule

/* sim/cfgchk_checker_asserts.sv */
// Concurrent checks on the option checker ports
`timescale 1ns/1ps
module cfgchk_asserts
  import cfgchk_pkg::*;
#(
  parameter int MAX_LEN = 19
) (
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         rst,
  // Command stream and context
  input  wire logic         cmd_start,
  input  wire logic         cmd_end,
  input  wire logic         chain_busy,
  input  wire logic         integrity_bad,
  input  wire logic         root_key_auth,
  // Response
  input  wire logic         rsp_valid,
  input  wire logic [15:0]  status_word,
  input  wire logic         cfg_apply,
  input  wire cfgchk_conf_t conf
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  logic busy_q;

  // Frame in progress
  always_ff @(posedge core_clk) begin
    if (rst) busy_q <= 1'b0;
    else if (cmd_start) busy_q <= 1'b1;
    else if (cmd_end) busy_q <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  rsp_latency_a: assert property (cmd_end && busy_q |-> ##2 rsp_valid)
    else $error("response not two cycles after end");
  rsp_pulse_a: assert property (rsp_valid |=> !rsp_valid)
    else $error("response longer than one cycle");
  apply_ok_a: assert property (cfg_apply == (rsp_valid && status_word == 16'h9100))
    else $error("apply pulse disagrees with status");
  sw_prefix_a: assert property (rsp_valid |-> status_word[15:8] == 8'h91)
    else $error("status word prefix wrong");
  abort_first_a: assert property (cmd_end && busy_q ##1 chain_busy |=> status_word == 16'h91ca)
    else $error("abort code missing");
  integ_next_a: assert property (cmd_end && busy_q ##1 (!chain_busy && integrity_bad) |=> status_word == 16'h911e)
    else $error("integrity code missing");
  auth_gate_a: assert property (cmd_end && busy_q ##1 (!chain_busy && !integrity_bad && !root_key_auth)
                                |=> status_word inside {16'h91ae, 16'h917e})
    else $error("command passed without authentication");
  hold_idle_a: assert property (!rsp_valid |-> $stable(status_word) && $stable(conf))
    else $error("outputs changed without response");
  once_sticky_a: assert property ($past(conf.amount_done) |-> conf.amount_done)
    else $error("one-time flag cleared");
  rst_value_a: assert property ($fell(rst) |-> conf.auth_fail_threshold == 16'h03e8 && conf.auth_fail_step == 16'h000a
                                && conf.strong_modulation)
    else $error("defaults wrong after reset");

  // Main scenarios reached
  cover property (cfg_apply);
  cover property (rsp_valid && status_word == 16'h91ca);
  cover property (rsp_valid && status_word == 16'h919d);
endmodule

bind cfgchk_checker cfgchk_asserts #(.MAX_LEN(MAX_LEN)) i_asserts (
  .core_clk(core_clk), .rst(rst), .cmd_start(cmd_start), .cmd_end(cmd_end), .chain_busy(chain_busy),
  .integrity_bad(integrity_bad), .root_key_auth(root_key_auth), .rsp_valid(rsp_valid),
  .status_word(status_word), .cfg_apply(cfg_apply), .conf(conf));

/* sim/test_config_command_option_checker.sv */
// Self-checking bench for the configuration command option checker
`timescale 1ns/1ps
module test_config_command_option_checker
  import cfgchk_pkg::*;
;
  typedef struct packed {
    logic [7:0]   opt;
    logic [4:0]   len;
    logic [151:0] pl;
    logic [4:0]   ctx;
    logic [7:0]   code;
  } cfgchk_row_t;
  function automatic logic [151:0] amt(logic [31:0] lo, logic [31:0] hi, logic [31:0] v);
    return {40'h0, 8'h03, v, hi, lo, 8'h01};
  endfunction
  // Context bits: abort, integrity, auth, exists, amount file
  localparam cfgchk_row_t ROWS [26] = '{
    '{8'h0b, 5'h01, 152'h01, 5'h04, 8'h00}, '{8'h0b, 5'h02, 152'h01, 5'h04, 8'h7e},
    '{8'h0b, 5'h01, 152'h01, 5'h1c, 8'hca}, '{8'h0b, 5'h01, 152'h01, 5'h0c, 8'h1e},
    '{8'h0b, 5'h02, 152'h01, 5'h00, 8'h7e}, '{8'h0b, 5'h01, 152'h01, 5'h00, 8'hae},
    '{8'h07, 5'h01, 152'h00, 5'h04, 8'h9e}, '{8'h0a, 5'h04, 152'h01, 5'h04, 8'h7e},
    '{8'h0a, 5'h05, 152'h01, 5'h04, 8'h9e}, '{8'h08, 5'h09, 152'h56_7804_0312_3402_0103, 5'h04, 8'h00},
    '{8'h08, 5'h07, 152'h56_7804_0312_3402_0103, 5'h04, 8'h7e}, '{8'h08, 5'h05, 152'h3f_0002_0101, 5'h04, 8'h9e},
    '{8'h08, 5'h03, 152'h06_0500, 5'h04, 8'h00}, '{8'h09, 5'h0e, amt(32'h0000_000a, 32'hffff_ffff, 32'h5), 5'h07, 8'h9e},
    '{8'h09, 5'h0e, amt(32'hffff_fffb, 32'h64, 32'hffff_fffa), 5'h07, 8'h9e},
    '{8'h09, 5'h0e, amt(32'hffff_fffb, 32'h64, 32'hffff_fffb), 5'h05, 8'hf0},
    '{8'h09, 5'h0e, amt(32'hffff_fffb, 32'h64, 32'hffff_fffb), 5'h06, 8'h9d},
    '{8'h09, 5'h0e, amt(32'hffff_fffb, 32'h64, 32'hffff_fffb), 5'h07, 8'h00},
    '{8'h09, 5'h0e, amt(32'hffff_fffb, 32'h64, 32'hffff_fffb), 5'h07, 8'h9d},
    '{8'h0b, 5'h01, 152'h00, 5'h04, 8'h00},
    '{8'h00, 5'h02, 152'h00, 5'h04, 8'h7e}, '{8'h02, 5'h04, 152'h00, 5'h04, 8'h7e},
    '{8'h03, 5'h02, 152'h00, 5'h04, 8'h00}, '{8'h04, 5'h01, 152'h00, 5'h04, 8'h7e},
    '{8'h05, 5'h0a, 152'h00, 5'h04, 8'h00}, '{8'h06, 5'h12, 152'h00, 5'h04, 8'h7e}};
  logic core_clk, rst, cmd_start, data_valid, cmd_end, rsp_valid, cfg_apply;
  logic [7:0] cmd_option, data_byte;
  logic [4:0] ctx;
  logic [15:0] status_word;
  cfgchk_conf_t conf;
  int fails, checks_done, k;

  cfgchk_checker #(.MAX_LEN(19)) i_dut (.core_clk(core_clk), .rst(rst), .cmd_start(cmd_start),
    .cmd_option(cmd_option), .data_valid(data_valid), .data_byte(data_byte), .cmd_end(cmd_end),
    .chain_busy(ctx[4]), .integrity_bad(ctx[3]), .root_key_auth(ctx[2]), .target_exists(ctx[1]),
    .target_is_amount(ctx[0]), .rsp_valid(rsp_valid), .status_word(status_word), .cfg_apply(cfg_apply),
    .conf(conf));
  cfgchk_reader i_rdr (.core_clk(core_clk), .cmd_start(cmd_start), .cmd_option(cmd_option),
    .data_valid(data_valid), .data_byte(data_byte), .cmd_end(cmd_end));

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [32:0] exp, input logic [32:0] got);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic run(input cfgchk_row_t r);
    ctx = r.ctx;
    i_rdr.send(r.opt, r.len, r.pl);
    @(posedge core_clk);
    #1;
    chk("rsp_valid", 1, rsp_valid);
    chk("status_word", {8'h91, r.code}, status_word);
    chk("cfg_apply", r.code == 8'h00, cfg_apply);
  endtask
  task automatic chk_def();
    chk("threshold", 16'h03e8, conf.auth_fail_threshold);
    chk("step", 16'h000a, conf.auth_fail_step);
    chk("ctr_en", 1, conf.auth_fail_counter_enable);
    chk("strong", 1, conf.strong_modulation);
    chk("status_rst", 0, status_word);
  endtask
  task automatic test_done();
    if (fails == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Clock
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  // Watchdog
  initial begin
    repeat (3000) @(posedge core_clk);
    fails++;
    test_done();
  end
  // Main sequence
  initial begin
    rst = 1'b1;
    ctx = 5'h04;
    repeat (6) @(posedge core_clk);
    #1;
    rst = 1'b0;
    chk_def();
    for (k = 0; k < 26; k++) run(ROWS[k]);
    chk("floor", 32'hffff_fffb, conf.amount_floor);
    chk("ceiling", 32'h0000_0064, conf.amount_ceiling);
    chk("current", 32'hffff_fffb, conf.amount_current);
    chk("file", 8'h01, conf.amount_file);
    chk("flags", 4'hf, {conf.amount_valid, conf.read_amount_free, conf.capped_credit_en, conf.amount_done});
    chk("strong", 0, conf.strong_modulation);
    run('{8'h0a, 5'h05, 152'h00_0712_3401, 5'h04, 8'h00});
    chk("ctr", 33'h1_1234_0007, {conf.auth_fail_counter_enable, conf.auth_fail_threshold, conf.auth_fail_step});
    run('{8'h0a, 5'h05, 152'h00, 5'h04, 8'h00});
    chk("ctr_off", 33'h0_1234_0007, {conf.auth_fail_counter_enable, conf.auth_fail_threshold, conf.auth_fail_step});
    rst = 1'b1;
    repeat (6) @(posedge core_clk);
    #1;
    rst = 1'b0;
    chk_def();
    chk("done_rst", 0, conf.amount_done);
    test_done();
  end
endmodule
